// ---- design/cstc_top.sv ----
// Charge status, thermistor supervision and backup regulator gating
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Start charging only when thermistor sits between hot and cold release levels.
// R2: Thermistor below disable ratio means grounded; temperature checks are ignored.
// R3: Below hot trip while charging pauses; resume above hot release level.
// R4: Above cold trip while charging pauses; resume below cold release level.
// R5: Charge timers hold their count during a temperature pause, then continue.
// R6: Thermistor over or under temperature puts charger into fault state.
// R7: Status pins are open drain: pull low or release, never drive high.
// R8: While charging, including precharge, charging pin low, others released.
// R9: Termination current reached: complete pin low, charging and fault released.
// R10: Charging fault blinks fault pin at 4Hz, 50% duty; others released.
// R11: Fault arising in constant voltage phase holds fault pin solidly low.
// R12: Charger disabled releases all three status pins.
// R13: Scaled battery below low threshold shuts regulator and circuitry off.
// R14: After low battery stay off until bias stable and lockout released.
// R15: Regulator enable input can turn backup regulator off on system power.
// R16: Regulator over temperature turns it off until it cools below release.
// R17: System should not run the backup regulator and charger together.
// R18: Toggling charger enable resets charge timers and clears latched faults.
// R19: Temperature fault in constant voltage phase ends in complete state once removed.
// R20: Regulator enable is active low; low turns the backup regulator on.
// R21: Blink from 125 ms divided intervals; comparators pass two flip-flops. The regulator lockout input is used unsynchronised.
module cstc_top
    import cstc_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Thermistor comparators
    input  wire logic temp_below_hot_trip_i,
    input  wire logic temp_above_hot_release_i,
    input  wire logic temp_above_cold_trip_i,
    input  wire logic temp_below_cold_release_i,
    input  wire logic temp_sense_disabled_i,
    // Battery and supply comparators
    input  wire logic low_cell_threshold_i,
    input  wire logic internal_bias_supply_ok_i,
    input  wire logic regulator_undervoltage_lockout_i,
    input  wire logic regulator_overtemp_i,
    // Enables
    input  wire logic charger_enable_input_i,
    input  wire logic regulator_enable_n_i,
    // Charger progress from the analog loop and timers
    input  wire logic below_min_voltage_i,
    input  wire logic cv_reached_i,
    input  wire logic termination_current_i,
    input  wire logic recharge_needed_i,
    input  wire logic timer_expired_i,
    // Charger control
    output logic      charge_run_o,
    output logic      timer_run_o,
    output logic      timer_clear_o,
    output logic      charge_state_cv_o,
    // Status pins, open drain
    output logic      charging_pin_o,
    output logic      charging_pin_oe_o,
    output logic      complete_pin_o,
    output logic      complete_pin_oe_o,
    output logic      fault_pin_o,
    output logic      fault_pin_oe_o,
    // Backup regulator and power state
    output logic      regulator_on_o,
    output logic      quiescent_o
);
    // Synchronised comparator bundle
    logic [CMP_W-1:0] cmp_raw;
    logic [CMP_W-1:0] cmp_s;
    logic             below_hot_trip;
    logic             above_hot_release;
    logic             above_cold_trip;
    logic             below_cold_release;
    logic             temp_disabled;
    logic             low_cell;
    logic             bias_ok;
    logic             reg_otp;

    assign cmp_raw = {regulator_overtemp_i, internal_bias_supply_ok_i,
                      low_cell_threshold_i, temp_sense_disabled_i,
                      temp_below_cold_release_i, temp_above_cold_trip_i,
                      temp_above_hot_release_i, temp_below_hot_trip_i};

    // Comparator levels except the regulator lockout cross two flip-flops before use
    cstc_sync #(.W(CMP_W)) u_sync ( // R21
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    (cmp_raw),
        .q_o    (cmp_s)
    );

    assign below_hot_trip     = cmp_s[0];
    assign above_hot_release  = cmp_s[1];
    assign above_cold_trip    = cmp_s[2];
    assign below_cold_release = cmp_s[3];
    assign temp_disabled      = cmp_s[4];
    assign low_cell           = cmp_s[5];
    assign bias_ok            = cmp_s[6];
    assign reg_otp            = cmp_s[7];

    // State registers
    cstc_state_t state_r;
    cstc_state_t state_nxt;
    logic        temp_pause_r;
    logic        temp_pause_nxt;
    logic        cv_fault_r;
    logic        cv_fault_nxt;
    logic        latched_r;
    logic        latched_nxt;
    logic        en_d_r;
    logic        en_d_nxt;
    logic        quiet_r;
    logic        quiet_nxt;
    logic        otp_off_r;
    logic        otp_off_nxt;
    logic        blink_phase;

    // Temperature qualifiers; grounded thermistor forces them all good
    logic temp_start_ok;
    logic temp_trip;
    logic temp_release;
    logic en_toggle;
    logic fault_blinking;

    assign temp_start_ok = temp_disabled || (above_hot_release && below_cold_release); // R1 R2
    assign temp_trip     = !temp_disabled && (below_hot_trip || above_cold_trip); // R2 R3 R4
    // Either trip direction releases only once past both release levels
    assign temp_release  = temp_disabled ||
                           ((!below_hot_trip || above_hot_release) &&
                            (!above_cold_trip || below_cold_release) &&
                            above_hot_release && below_cold_release); // R3 R4
    // Any edge of the enable input counts as a toggle
    assign en_toggle     = charger_enable_input_i != en_d_r; // R18

    // Charger state, temperature pause, latched faults and power state
    always_comb begin
        state_nxt      = state_r;
        temp_pause_nxt = temp_pause_r;
        cv_fault_nxt   = cv_fault_r;
        latched_nxt    = latched_r;
        en_d_nxt       = charger_enable_input_i;
        quiet_nxt      = quiet_r;
        otp_off_nxt    = otp_off_r;
        // Low cell shuts everything; wake only on bias ok and lockout clear
        if (low_cell) begin
            quiet_nxt = 1'b1; // R13
        end else if (quiet_r && bias_ok && !regulator_undervoltage_lockout_i) begin
            quiet_nxt = 1'b0; // R14
        end
        // Hysteresis is done by the analog flag; it stays set until 15 C below
        otp_off_nxt = reg_otp; // R16
        if (en_toggle) begin
            latched_nxt  = 1'b0; // R18
            cv_fault_nxt = 1'b0;
            temp_pause_nxt = 1'b0;
        end
        if (quiet_r || !charger_enable_input_i) begin
            state_nxt      = CSTC_OFF;
            temp_pause_nxt = 1'b0;
        end else begin
            unique case (state_r)
                CSTC_OFF: begin
                    if (!latched_r && !en_toggle && temp_start_ok) begin // R1
                        state_nxt = below_min_voltage_i ? CSTC_PRE : CSTC_CC;
                    end
                end
                CSTC_PRE, CSTC_CC, CSTC_CV: begin
                    if (timer_expired_i) begin
                        state_nxt    = CSTC_FAULT;
                        latched_nxt  = 1'b1; // R18
                        cv_fault_nxt = state_r == CSTC_CV; // R11
                    end else if (temp_trip) begin
                        state_nxt      = CSTC_FAULT; // R6
                        temp_pause_nxt = 1'b1; // R5
                        cv_fault_nxt   = state_r == CSTC_CV; // R11
                    end else if (state_r == CSTC_PRE && !below_min_voltage_i) begin
                        state_nxt = CSTC_CC;
                    end else if (state_r == CSTC_CC && cv_reached_i) begin
                        state_nxt = CSTC_CV;
                    end else if (state_r == CSTC_CV && termination_current_i) begin
                        state_nxt = CSTC_DONE; // R9
                    end
                end
                CSTC_DONE: begin
                    if (recharge_needed_i && temp_start_ok) begin
                        state_nxt = below_min_voltage_i ? CSTC_PRE : CSTC_CC;
                    end
                end
                CSTC_FAULT: begin
                    // Timer faults stay until the enable is toggled
                    if (en_toggle) begin
                        state_nxt = CSTC_OFF; // R18
                    end else if (temp_pause_r && !latched_r && temp_release) begin
                        temp_pause_nxt = 1'b0;
                        cv_fault_nxt   = 1'b0;
                        // Resume in precharge or CC by battery voltage, or finish if it was in CV
                        if (cv_fault_r) begin
                            state_nxt = CSTC_DONE; // R19
                        end else begin
                            state_nxt = below_min_voltage_i ? CSTC_PRE : CSTC_CC; // R3 R4
                        end
                    end
                end
                default: state_nxt = CSTC_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_r      <= CSTC_OFF;
            temp_pause_r <= 1'b0;
            cv_fault_r   <= 1'b0;
            latched_r    <= 1'b0;
            en_d_r       <= 1'b0;
            quiet_r      <= 1'b0;
            otp_off_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            temp_pause_r <= temp_pause_nxt;
            cv_fault_r   <= cv_fault_nxt;
            latched_r    <= latched_nxt;
            en_d_r       <= en_d_nxt;
            quiet_r      <= quiet_nxt;
            otp_off_r    <= otp_off_nxt;
        end
    end

    // Blink runs only for faults outside CV so it starts with a low half
    assign fault_blinking = state_nxt == CSTC_FAULT && !cv_fault_nxt;

    cstc_blink u_blink ( // R10 R21
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .run_i   (fault_blinking),
        .phase_o (blink_phase)
    );

    // Registered outputs
    logic run_r;
    logic run_nxt;
    logic tmr_run_r;
    logic tmr_run_nxt;
    logic tmr_clr_r;
    logic tmr_clr_nxt;
    logic cv_r;
    logic cv_nxt;
    logic chg_oe_r;
    logic chg_oe_nxt;
    logic cmp_oe_r;
    logic cmp_oe_nxt;
    logic flt_oe_r;
    logic flt_oe_nxt;
    logic reg_on_r;
    logic reg_on_nxt;
    logic quiet_o_r;

    // Pin drive: enable high means pulling low; data is always zero
    always_comb begin
        run_nxt     = state_r inside {CSTC_PRE, CSTC_CC, CSTC_CV};
        // Timers freeze while paused so the count resumes instead of restarting
        tmr_run_nxt = state_r inside {CSTC_CC, CSTC_CV}; // R5
        tmr_clr_nxt = en_toggle; // R18
        cv_nxt      = state_r == CSTC_CV;
        chg_oe_nxt  = state_r inside {CSTC_PRE, CSTC_CC, CSTC_CV}; // R8
        cmp_oe_nxt  = state_r == CSTC_DONE; // R9
        flt_oe_nxt  = state_r == CSTC_FAULT && (cv_fault_r || !blink_phase); // R10 R11
        if (state_r == CSTC_OFF) begin
            chg_oe_nxt = 1'b0; // R12
            cmp_oe_nxt = 1'b0;
            flt_oe_nxt = 1'b0;
        end
        // Active low enable; no interlock against charging is imposed here
        reg_on_nxt = !regulator_enable_n_i && !otp_off_r && !quiet_r; // R15 R16 R20 R13
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_r     <= 1'b0;
            tmr_run_r <= 1'b0;
            tmr_clr_r <= 1'b0;
            cv_r      <= 1'b0;
            chg_oe_r  <= 1'b0;
            cmp_oe_r  <= 1'b0;
            flt_oe_r  <= 1'b0;
            reg_on_r  <= 1'b0;
            quiet_o_r <= 1'b0;
        end else begin
            run_r     <= run_nxt;
            tmr_run_r <= tmr_run_nxt;
            tmr_clr_r <= tmr_clr_nxt;
            cv_r      <= cv_nxt;
            chg_oe_r  <= chg_oe_nxt;
            cmp_oe_r  <= cmp_oe_nxt;
            flt_oe_r  <= flt_oe_nxt;
            reg_on_r  <= reg_on_nxt;
            quiet_o_r <= quiet_r;
        end
    end

    assign charge_run_o      = run_r;
    assign timer_run_o       = tmr_run_r;
    assign timer_clear_o     = tmr_clr_r;
    assign charge_state_cv_o = cv_r;
    // Data lines are constant zero: open drain never drives high
    assign charging_pin_o    = 1'b0; // R7
    assign complete_pin_o    = 1'b0; // R7
    assign fault_pin_o       = 1'b0; // R7
    assign charging_pin_oe_o = chg_oe_r;
    assign complete_pin_oe_o = cmp_oe_r;
    assign fault_pin_oe_o    = flt_oe_r;
    assign regulator_on_o    = reg_on_r;
    assign quiescent_o       = quiet_o_r;
endmodule
`default_nettype wire

// ---- inc/cstc_pkg.sv ----
// Constants and state type shared by the charge status and thermal supervisor
package cstc_pkg;
    // Clock rate and blink timing
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned BLINK_HALF_MS  = 125;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned BLINK_CNT_W    = 22;
    // Synchroniser depth
    localparam int unsigned SYNC_STAGES    = 2;
    // Width of the synchronised comparator bundle
    localparam int unsigned CMP_W          = 8;
    // Charger states
    typedef enum logic [2:0] {
        CSTC_OFF,
        CSTC_PRE,
        CSTC_CC,
        CSTC_CV,
        CSTC_DONE,
        CSTC_FAULT
    } cstc_state_t;
endpackage

// ---- design/cstc_sync.sv ----
// Two flip-flop synchroniser for a bundle of comparator levels
`timescale 1ns/1ps
`default_nettype none
module cstc_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    // Levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // First stage only feeds the second
    always_comb begin
        meta_nxt = d_i;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q_o = q_r;
endmodule
`default_nettype wire

// ---- design/cstc_blink.sv ----
// Divider producing the fault blink phase
`timescale 1ns/1ps
`default_nettype none
module cstc_blink
    import cstc_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic srst_i,
    // Run while blinking is wanted; phase restarts otherwise
    input  wire logic run_i,
    output logic      phase_o
);
    logic [BLINK_CNT_W-1:0] cnt_r;
    logic [BLINK_CNT_W-1:0] cnt_nxt;
    logic                   phase_r;
    logic                   phase_nxt;

    // Half period count, phase low first so the pin pulls as soon as a fault starts
    always_comb begin
        cnt_nxt   = cnt_r;
        phase_nxt = phase_r;
        if (!run_i) begin
            cnt_nxt   = '0;
            phase_nxt = 1'b0;
        end else if (cnt_r == BLINK_CNT_W'(BLINK_HALF_CYC - 1)) begin
            cnt_nxt   = '0;
            phase_nxt = ~phase_r;
        end else begin
            cnt_nxt = cnt_r + BLINK_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt_r   <= '0;
            phase_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    assign phase_o = phase_r;
endmodule
`default_nettype wire

// ---- tb/cstc_properties.sv ----
// Concurrent checks on the charge status supervisor ports
`timescale 1ns/1ps
`default_nettype none
module cstc_properties (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Watched inputs
    input wire logic temp_below_hot_trip_i,
    input wire logic temp_above_hot_release_i,
    input wire logic temp_above_cold_trip_i,
    input wire logic temp_below_cold_release_i,
    input wire logic temp_sense_disabled_i,
    input wire logic regulator_overtemp_i,
    input wire logic charger_enable_input_i,
    input wire logic regulator_enable_n_i,
    // Watched outputs
    input wire logic charge_run_o,
    input wire logic timer_run_o,
    input wire logic timer_clear_o,
    input wire logic charging_pin_o,
    input wire logic complete_pin_o,
    input wire logic fault_pin_o,
    input wire logic charging_pin_oe_o,
    input wire logic complete_pin_oe_o,
    input wire logic fault_pin_oe_o,
    input wire logic regulator_on_o,
    input wire logic quiescent_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // Five cycles cover two sync flops, the state edge and the output edge
    sequence s_hot;
        (temp_below_hot_trip_i && !temp_above_hot_release_i && !temp_sense_disabled_i) [*5];
    endsequence
    sequence s_cold;
        (temp_above_cold_trip_i && !temp_below_cold_release_i && !temp_sense_disabled_i) [*5];
    endsequence
    sequence s_pulse;
        timer_clear_o ##1 !timer_clear_o;
    endsequence

    property p_open_drain;
        !(charging_pin_o || complete_pin_o || fault_pin_o);
    endproperty
    property p_one_led;
        $onehot0({charging_pin_oe_o, complete_pin_oe_o, fault_pin_oe_o});
    endproperty
    property p_disabled;
        !charger_enable_input_i [*4] |-> !(charging_pin_oe_o || complete_pin_oe_o || fault_pin_oe_o);
    endproperty
    property p_hot_pause;
        s_hot |-> !charge_run_o && !timer_run_o;
    endproperty
    property p_cold_pause;
        s_cold |-> !charge_run_o && !timer_run_o;
    endproperty
    property p_timer_in_run;
        timer_run_o |-> charge_run_o;
    endproperty
    property p_clear_pulse;
        $changed(charger_enable_input_i) |-> ##[1:3] s_pulse;
    endproperty
    property p_quiet;
        quiescent_o [*2] |-> !regulator_on_o && !charge_run_o;
    endproperty
    property p_reg_n;
        regulator_enable_n_i [*3] |-> !regulator_on_o;
    endproperty
    property p_reg_hot;
        regulator_overtemp_i [*5] |-> !regulator_on_o;
    endproperty

    a_open_drain: assert property (p_open_drain) else $error("status pin driven high");
    a_one_led: assert property (p_one_led) else $error("two status pins low");
    a_disabled: assert property (p_disabled) else $error("pin low while disabled");
    a_hot_pause: assert property (p_hot_pause) else $error("charging while hot");
    a_cold_pause: assert property (p_cold_pause) else $error("charging while cold");
    a_timer_in_run: assert property (p_timer_in_run) else $error("timer runs paused");
    a_clear_pulse: assert property (p_clear_pulse) else $error("no timer clear");
    a_quiet: assert property (p_quiet) else $error("active in quiescent");
    a_reg_n: assert property (p_reg_n) else $error("regulator on while off");
    a_reg_hot: assert property (p_reg_hot) else $error("regulator on while hot");
endmodule

bind cstc_top cstc_properties i_cstc_properties (.*);
`default_nettype wire

// ---- tb/cstc_status_model.sv ----
// Pull-up resistors on the three open-drain status pins
`timescale 1ns/1ps
`default_nettype none
module cstc_status_model (
    // Pin values and enables from the supervisor
    input  wire logic [2:0] pin_i,
    input  wire logic [2:0] oe_i,
    // Levels seen on the wires
    output logic      [2:0] lvl_o
);
    // A released pin floats up to the pull-up level, so a reader never sees stale data
    assign lvl_o = (oe_i & pin_i) | ~oe_i;
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the charge status and thermal supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cstc_pkg::*;
    // Thermistor {below hot trip, above hot release, above cold trip, below cold release, grounded}
    localparam logic [4:0] T_OK = 5'h0a, T_HOT = 5'h12, T_MIDH = 5'h02;
    localparam logic [4:0] T_COLD = 5'h0c, T_MIDC = 5'h08, T_GND = 5'h13;
    // Supplies {low cell, bias ok, lockout, regulator hot}
    localparam logic [3:0] S_OK = 4'h4, S_LOW = 4'hc, S_NOB = 4'h0, S_UV = 4'h6, S_RH = 4'h5;
    // Control {enable, regulator off, below min, cv, term, recharge, expired}
    // Expected {charging, complete, fault levels, run, regulator on, quiescent}
    // Regulator only runs while the charger is off, as the system should keep it
    localparam logic [21:0] ROWS [14] = '{
        {T_OK, S_OK, 7'h20, 6'h38}, {T_OK, S_OK, 7'h70, 6'h1c},
        {T_OK, S_OK, 7'h60, 6'h1c}, {T_OK, S_OK, 7'h68, 6'h1c},
        {T_OK, S_OK, 7'h6c, 6'h28}, {T_OK, S_OK, 7'h20, 6'h38},
        {T_OK, S_OK, 7'h00, 6'h3a}, {T_OK, S_RH, 7'h00, 6'h38},
        {T_OK, S_OK, 7'h00, 6'h3a}, {T_GND, S_OK, 7'h60, 6'h1c},
        {T_GND, S_LOW, 7'h60, 6'h39}, {T_GND, S_NOB, 7'h60, 6'h39},
        {T_GND, S_UV, 7'h60, 6'h39}, {T_GND, S_OK, 7'h60, 6'h1c}
    };
    logic        clk = 1'h0;
    logic        srst = 1'h1;
    logic [15:0] in_v = {T_OK, S_OK, 7'h20};
    logic        run, trun, tclr, cvst, reg_on, quies;
    logic [2:0]  pin, oe, lvl;
    int          n_errors = 0, samples_checked = 0, n_clr = 0, clr0 = 0;
    wire  [5:0]  obs = {lvl, run, reg_on, quies};

    // 25 MHz clock
    always #20 clk = ~clk;
    // Count timer clear pulses
    always @(posedge clk) if (tclr === 1'h1) n_clr <= n_clr + 1;

    cstc_top i_cstc_top (
        .clk_i(clk), .srst_i(srst),
        .temp_below_hot_trip_i(in_v[15]), .temp_above_hot_release_i(in_v[14]),
        .temp_above_cold_trip_i(in_v[13]), .temp_below_cold_release_i(in_v[12]),
        .temp_sense_disabled_i(in_v[11]), .low_cell_threshold_i(in_v[10]),
        .internal_bias_supply_ok_i(in_v[9]), .regulator_undervoltage_lockout_i(in_v[8]),
        .regulator_overtemp_i(in_v[7]), .charger_enable_input_i(in_v[6]),
        .regulator_enable_n_i(in_v[5]), .below_min_voltage_i(in_v[4]),
        .cv_reached_i(in_v[3]), .termination_current_i(in_v[2]),
        .recharge_needed_i(in_v[1]), .timer_expired_i(in_v[0]),
        .charge_run_o(run), .timer_run_o(trun), .timer_clear_o(tclr),
        .charge_state_cv_o(cvst),
        .charging_pin_o(pin[2]), .charging_pin_oe_o(oe[2]),
        .complete_pin_o(pin[1]), .complete_pin_oe_o(oe[1]),
        .fault_pin_o(pin[0]), .fault_pin_oe_o(oe[0]),
        .regulator_on_o(reg_on), .quiescent_o(quies)
    );
    cstc_status_model i_cstc_status_model (.pin_i(pin), .oe_i(oe), .lvl_o(lvl));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Inputs move on the falling edge, then settle n cycles
    task automatic go(input logic [15:0] v, input int n);
        @(negedge clk);
        in_v = v;
        repeat (n) @(negedge clk);
    endtask

    task automatic wrap_up;
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk({2'h0, oe, run, trun, tclr}, 8'h00);
        srst = 1'h0;
        for (int i = 0; i < 14; i++) begin
            go(ROWS[i][21:6], 12);
            chk({2'h0, obs}, {2'h0, ROWS[i][5:0]});
        end
        // Pause, hold in the hysteresis band, then resume with timers running
        for (int k = 0; k < 2; k++) begin
            go({k ? T_COLD : T_HOT, S_OK, 7'h60}, 12);
            chk({obs, trun, 1'h0}, 8'hc0);
            go({k ? T_MIDC : T_MIDH, S_OK, 7'h60}, 200);
            chk({obs, trun, 1'h0}, 8'hc0);
            go({T_OK, S_OK, 7'h60}, 12);
            chk({obs, trun, 1'h0}, 8'h72);
        end
        // Fault in constant voltage stays solid and ends complete
        go({T_OK, S_OK, 7'h68}, 12);
        chk({7'h0, cvst}, 8'h01);
        go({T_HOT, S_OK, 7'h68}, 12);
        chk({2'h0, obs}, 8'h30);
        go({T_OK, S_OK, 7'h68}, 12);
        chk({2'h0, obs}, 8'h28);
        // Safety timer fault latches until the enable toggles
        clr0 = n_clr;
        go({T_OK, S_OK, 7'h20}, 12);
        go({T_OK, S_OK, 7'h60}, 12);
        go({T_OK, S_OK, 7'h61}, 12);
        chk({2'h0, obs}, 8'h30);
        go({T_OK, S_OK, 7'h60}, 12);
        chk({2'h0, obs}, 8'h30);
        go({T_OK, S_OK, 7'h20}, 4);
        go({T_OK, S_OK, 7'h60}, 12);
        chk({2'h0, obs}, 8'h1c);
        chk(8'(n_clr - clr0), 8'h04);
        // No start outside the temperature window
        go({T_HOT, S_OK, 7'h20}, 12);
        go({T_HOT, S_OK, 7'h60}, 12);
        chk({7'h0, run}, 8'h00);
        go({T_MIDH, S_OK, 7'h60}, 12);
        chk({7'h0, run}, 8'h00);
        go({T_OK, S_OK, 7'h60}, 12);
        chk({7'h0, run}, 8'h01);
        // Reset mid-charge drops every output; the held enable then reads as one fresh toggle
        clr0 = n_clr;
        srst = 1'h1;
        repeat (2) @(negedge clk);
        chk({trun, tclr, obs}, 8'h38);
        srst = 1'h0;
        go({T_OK, S_OK, 7'h60}, 12);
        chk({2'h0, obs}, 8'h1c);
        chk(8'(n_clr - clr0), 8'h01);
        wrap_up();
    end

    // Watchdog: the sequence needs well under 1500 cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
